/* File: spal_pkg.sv */
// constants, types and decode helpers for the serial programming access layer
// assumes a byte-wide data space and i/o space behind a simple request bus
package spal_pkg;

  localparam logic [7:0] OP_LD_IND = 8'h20;
  localparam logic [7:0] OP_LD_INC = 8'h24;
  localparam logic [7:0] OP_ST_IND = 8'h60;
  localparam logic [7:0] OP_ST_INC = 8'h64;
  localparam logic [7:0] OP_ST_PTR = 8'h68;
  localparam logic [7:0] MASK_ST_PTR = 8'hFE;
  localparam logic [7:0] OP_IO_RD = 8'h10;
  localparam logic [7:0] OP_IO_WR = 8'h90;
  localparam logic [7:0] MASK_IO = 8'h90;
  localparam logic [7:0] OP_CS_LD = 8'h80;
  localparam logic [7:0] OP_CS_ST = 8'hC0;
  localparam logic [7:0] MASK_CS = 8'hF0;
  localparam logic [7:0] OP_KEY = 8'hE0;
  localparam int POSTINC_BIT = 2;
  localparam int PTR_SEL_BIT = 0;

  localparam int FRAME_BITS = 12;
  localparam int RX_BITS = 11;
  localparam int IDLE_EXTRA = 2;
  localparam logic [2:0] KEY_LAST = 3'h7;
  localparam int PTR_W = 16;
  localparam int KEY_W = 64;

  // 128 guard bit times; with IDLE_EXTRA the phy sends 130 idle bit times
  localparam logic [7:0] GUARD_RESET = 8'h80;
  localparam logic [3:0] CSS_PHY_CTRL = 4'h2;
  localparam logic [3:0] CSS_IDENT = 4'hF;
  localparam int CSS_DEPTH = 16;

  typedef enum logic [3:0] {K_BAD, K_LD_IND, K_ST_IND, K_ST_PTR, K_IO_RD, K_IO_WR,
                            K_CS_LD, K_CS_ST, K_KEY} spal_kind_t;
  typedef enum logic [2:0] {A_IDLE, A_OPER, A_KEY, A_WAIT_WR, A_WAIT_RD, A_CS_RD, A_TX,
                            A_ERR} spal_astate_t;
  typedef enum logic [1:0] {TX_IDLE, TX_GUARD, TX_FRAME} spal_txstate_t;

  typedef struct packed {
    logic write;
    logic io;
    logic [15:0] addr;
    logic [7:0] wdata;
  } spal_bus_req_t;

  typedef struct packed {
    logic parity;
    logic frame;
    logic brk;
    logic collision;
  } spal_exc_t;

  function automatic spal_kind_t spal_decode(input logic [7:0] op);
    if (op == OP_LD_IND || op == OP_LD_INC) return K_LD_IND;
    if (op == OP_ST_IND || op == OP_ST_INC) return K_ST_IND;
    if ((op & MASK_ST_PTR) == OP_ST_PTR) return K_ST_PTR;
    if ((op & MASK_IO) == OP_IO_RD) return K_IO_RD;
    if ((op & MASK_IO) == OP_IO_WR) return K_IO_WR;
    if ((op & MASK_CS) == OP_CS_LD) return K_CS_LD;
    if ((op & MASK_CS) == OP_CS_ST) return K_CS_ST;
    if (op == OP_KEY) return K_KEY;
    return K_BAD;
  endfunction : spal_decode

  // six-bit direct i/o address split around bit 4 of the opcode
  function automatic logic [15:0] spal_io_addr(input logic [7:0] op);
    return {10'h000, op[6:5], op[3:0]};
  endfunction : spal_io_addr

endpackage : spal_pkg

/* File: spal_css_mem.sv */
// small control/status scratch memory with registered read data
// assumes one clock; write and read ports are independent
`timescale 1ns/1ps
module spal_css_mem #(
  parameter int DEPTH = spal_pkg::CSS_DEPTH,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : spal_css_mem

/* File: spal_phy.sv */
// half-duplex serial physical layer on the programmer's clock
// assumes data line sampled on rising edges; tx_out and tx_oe change on falling edges
`timescale 1ns/1ps
module spal_phy (
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic rx_line,
  input wire logic tx_mode,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] guard,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output spal_pkg::spal_exc_t exc,
  output logic tx_done,
  output logic tx_busy,
  output logic tx_out,
  output logic tx_oe
);

  typedef struct packed {
    logic rx_busy;
    logic rx_wait_high;
    logic [3:0] rx_cnt;
    logic [10:0] rx_sh;
    spal_pkg::spal_txstate_t tstate;
    logic [8:0] t_cnt;
    logic [11:0] t_sh;
    logic bit_v;
    logic drive;
    logic rx_valid;
    logic [7:0] rx_byte;
    spal_pkg::spal_exc_t exc;
    logic tx_done;
  } spal_phy_state_t;

  spal_phy_state_t s;
  spal_phy_state_t next_s;

  always_comb begin
    logic [10:0] full;
    logic nb;
    full = '0;
    nb = 1'b1;
    next_s = s;
    next_s.rx_valid = 1'b0;
    next_s.exc = '0;
    next_s.tx_done = 1'b0;
    if (!tx_mode && s.tstate == spal_pkg::TX_IDLE) begin
      if (s.rx_wait_high) begin
        next_s.rx_wait_high = !rx_line;
      end else if (!s.rx_busy) begin
        next_s.rx_busy = !rx_line;
        next_s.rx_cnt = 4'h0;
      end else begin
        full = {rx_line, s.rx_sh[10:1]};
        next_s.rx_sh = full;
        next_s.rx_cnt = s.rx_cnt + 4'h1;
        if (s.rx_cnt == 4'(spal_pkg::RX_BITS - 1)) begin
          next_s.rx_busy = 1'b0;
          if (full == '0) begin
            next_s.exc.brk = 1'b1;
            next_s.rx_wait_high = 1'b1;
          end else if (!full[10] || !full[9]) begin
            next_s.exc.frame = 1'b1;
          end else if (^full[8:0]) begin
            next_s.exc.parity = 1'b1;
          end else begin
            next_s.rx_valid = 1'b1;
            next_s.rx_byte = full[7:0];
          end
        end
      end
    end
    case (s.tstate)
      spal_pkg::TX_IDLE: begin
        next_s.drive = 1'b0;
        next_s.bit_v = 1'b1;
        if (tx_start && tx_mode) begin
          next_s.tstate = spal_pkg::TX_GUARD;
          next_s.t_cnt = {1'b0, guard} + 9'(spal_pkg::IDLE_EXTRA - 1);
          next_s.t_sh = {2'b11, ^tx_byte, tx_byte, 1'b0};
          next_s.drive = 1'b1;
        end
      end
      spal_pkg::TX_GUARD, spal_pkg::TX_FRAME: begin
        if (s.tstate == spal_pkg::TX_FRAME && s.t_cnt == 9'h000) begin
          next_s.tstate = spal_pkg::TX_IDLE;
          next_s.tx_done = 1'b1;
        end else if (s.tstate == spal_pkg::TX_GUARD && s.t_cnt == 9'h000) begin
          next_s.tstate = spal_pkg::TX_FRAME;
          next_s.t_cnt = 9'(spal_pkg::FRAME_BITS - 1);
          nb = s.t_sh[0];
          next_s.t_sh = {1'b1, s.t_sh[11:1]};
        end else begin
          next_s.t_cnt = s.t_cnt - 9'h001;
          nb = (s.tstate == spal_pkg::TX_FRAME) ? s.t_sh[0] : 1'b1;
          next_s.t_sh = (s.tstate == spal_pkg::TX_FRAME) ? {1'b1, s.t_sh[11:1]} : s.t_sh;
        end
        next_s.bit_v = nb;
        next_s.drive = !nb || !s.bit_v;
        if (next_s.tstate == spal_pkg::TX_IDLE) begin
          next_s.bit_v = 1'b1;
          next_s.drive = 1'b0;
        end
        if (!s.drive && !rx_line) begin
          next_s.exc.collision = 1'b1;
          next_s.tstate = spal_pkg::TX_IDLE;
          next_s.tx_done = 1'b0;
          next_s.bit_v = 1'b1;
          next_s.drive = 1'b0;
        end
        if (!tx_mode) begin
          next_s.tstate = spal_pkg::TX_IDLE;
          next_s.drive = 1'b0;
        end
      end
      default: begin
        next_s.tstate = spal_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      s <= '0;
      s.bit_v <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // pin copy on the falling edge so the line changes between sampling edges
  always_ff @(negedge link_clk) begin
    if (link_rst) begin
      tx_oe <= 1'b0;
      tx_out <= 1'b1;
    end else begin
      tx_oe <= s.drive;
      tx_out <= s.bit_v;
    end
  end

  assign rx_valid = s.rx_valid;
  assign rx_byte = s.rx_byte;
  assign exc = s.exc;
  assign tx_done = s.tx_done;
  assign tx_busy = s.tstate != spal_pkg::TX_IDLE;

  sequence seq_two_idle;
    s.bit_v [*2];
  endsequence

  chk_zero_drive: assert property (@(posedge link_clk) disable iff (link_rst)
    (s.tstate != spal_pkg::TX_IDLE && !s.bit_v) |-> (tx_oe && !tx_out))
    else $error("zero bit not actively driven");
  chk_ones_release: assert property (@(posedge link_clk) disable iff (link_rst)
    (s.tstate != spal_pkg::TX_IDLE && s.bit_v && $past(s.bit_v) && $past(s.tstate) != spal_pkg::TX_IDLE)
    |-> !tx_oe)
    else $error("driver not released on repeated one");
  chk_collision_flag: assert property (@(posedge link_clk) disable iff (link_rst)
    (s.tstate != spal_pkg::TX_IDLE && tx_mode && !s.drive && !rx_line)
    |=> (exc.collision && s.tstate == spal_pkg::TX_IDLE))
    else $error("collision not flagged");
  chk_stop_high: assert property (@(posedge link_clk) disable iff (link_rst)
    (s.tstate == spal_pkg::TX_FRAME && s.t_cnt <= 9'h001) |-> s.bit_v)
    else $error("stop bit not high");
  chk_guard_idle: assert property (@(posedge link_clk) disable iff (link_rst)
    (s.tstate == spal_pkg::TX_IDLE && tx_start && tx_mode) |=> seq_two_idle)
    else $error("fewer than two idle bits before start");

endmodule : spal_phy

/* File: spal_top.sv */
// access layer and clock-domain bridge of the serial programming port
// assumes the programmer clocks prog_clock_in through every frame and reply wait
`timescale 1ns/1ps
module spal_top #(
  // arbitrary identification value
  parameter logic [7:0] IDENT_CODE = 8'h5A
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic prog_clock_in,
  input wire logic prog_data_in,
  output logic prog_data_out,
  output logic prog_data_oe,
  output logic bus_valid,
  output spal_pkg::spal_bus_req_t bus_req,
  input wire logic bus_ready,
  input wire logic [7:0] bus_rdata,
  output logic key_valid,
  output logic [63:0] key_value
);

  typedef struct packed {
    spal_pkg::spal_astate_t astate;
    spal_pkg::spal_kind_t kind;
    logic [7:0] op;
    logic [spal_pkg::PTR_W-1:0] ptr;
    logic [7:0] guard;
    spal_pkg::spal_bus_req_t req;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic [spal_pkg::KEY_W-1:0] key;
    logic [2:0] key_cnt;
    logic key_tgl;
    logic tx_start;
    logic [7:0] tx_byte;
    logic held_vld;
    logic [7:0] held;
  } spal_link_state_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic key_s1;
    logic key_s2;
    logic key_s3;
    logic bus_valid;
    spal_pkg::spal_bus_req_t bus_req;
    logic [7:0] rdata;
    logic ack_tgl;
    logic key_valid;
    logic [spal_pkg::KEY_W-1:0] key_value;
  } spal_sys_state_t;

  spal_link_state_t l;
  spal_link_state_t next_l;
  spal_sys_state_t s;
  spal_sys_state_t next_s;
  logic rst_s1;
  logic link_rst;
  logic rx_valid;
  logic [7:0] rx_byte;
  spal_pkg::spal_exc_t exc;
  logic any_exc;
  logic tx_done;
  logic tx_busy;
  logic tx_mode;
  logic in_vld;
  logic [7:0] in_byte;
  logic ack_edge;
  logic css_we;
  logic [7:0] css_rdata;

  // reset carried into the link domain
  always_ff @(posedge prog_clock_in) begin
    rst_s1 <= reset;
    link_rst <= rst_s1;
  end

  assign tx_mode = l.astate == spal_pkg::A_TX;
  assign any_exc = |exc;

  spal_phy u_phy (
    .link_clk(prog_clock_in),
    .link_rst(link_rst),
    .rx_line(prog_data_in),
    .tx_mode(tx_mode),
    .tx_start(l.tx_start),
    .tx_byte(l.tx_byte),
    .guard(l.guard),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .exc(exc),
    .tx_done(tx_done),
    .tx_busy(tx_busy),
    .tx_out(prog_data_out),
    .tx_oe(prog_data_oe)
  );

  spal_css_mem #(
    .DEPTH(spal_pkg::CSS_DEPTH),
    .WIDTH(8)
  ) u_css (
    .clk(prog_clock_in),
    .we(css_we),
    .waddr(l.op[3:0]),
    .wdata(in_byte),
    .raddr(in_byte[3:0]),
    .rdata(css_rdata)
  );

  always_comb begin
    next_l = l;
    next_l.tx_start = 1'b0;
    next_l.ack_s1 = s.ack_tgl;
    next_l.ack_s2 = l.ack_s1;
    next_l.ack_s3 = l.ack_s2;
    ack_edge = l.ack_s2 ^ l.ack_s3;
    in_vld = rx_valid || l.held_vld;
    in_byte = rx_valid ? rx_byte : l.held;
    css_we = 1'b0;
    if (any_exc) begin
      next_l.held_vld = 1'b0;
      if (l.astate == spal_pkg::A_ERR && exc.brk) begin
        next_l.astate = spal_pkg::A_IDLE;
      end else begin
        next_l.astate = spal_pkg::A_ERR;
      end
    end else begin
      case (l.astate)
        spal_pkg::A_IDLE: begin
          if (in_vld) begin
            next_l.held_vld = 1'b0;
            next_l.op = in_byte;
            next_l.kind = spal_pkg::spal_decode(in_byte);
            case (spal_pkg::spal_decode(in_byte))
              spal_pkg::K_LD_IND, spal_pkg::K_IO_RD: begin
                next_l.req.write = 1'b0;
                next_l.req.io = spal_pkg::spal_decode(in_byte) == spal_pkg::K_IO_RD;
                next_l.req.addr = next_l.req.io ? spal_pkg::spal_io_addr(in_byte) : l.ptr;
                next_l.req.wdata = 8'h00;
                next_l.req_tgl = !l.req_tgl;
                if (!next_l.req.io && in_byte[spal_pkg::POSTINC_BIT]) begin
                  next_l.ptr = l.ptr + 16'h0001;
                end
                next_l.astate = spal_pkg::A_WAIT_RD;
              end
              spal_pkg::K_CS_LD: next_l.astate = spal_pkg::A_CS_RD;
              spal_pkg::K_KEY: begin
                next_l.key_cnt = 3'h0;
                next_l.astate = spal_pkg::A_KEY;
              end
              spal_pkg::K_BAD: next_l.astate = spal_pkg::A_ERR;
              default: next_l.astate = spal_pkg::A_OPER;
            endcase
          end
        end
        spal_pkg::A_OPER: begin
          if (in_vld) begin
            next_l.held_vld = 1'b0;
            next_l.astate = spal_pkg::A_IDLE;
            case (l.kind)
              spal_pkg::K_ST_IND, spal_pkg::K_IO_WR: begin
                next_l.req.write = 1'b1;
                next_l.req.io = l.kind == spal_pkg::K_IO_WR;
                next_l.req.addr = next_l.req.io ? spal_pkg::spal_io_addr(l.op) : l.ptr;
                next_l.req.wdata = in_byte;
                next_l.req_tgl = !l.req_tgl;
                if (!next_l.req.io && l.op[spal_pkg::POSTINC_BIT]) begin
                  next_l.ptr = l.ptr + 16'h0001;
                end
                next_l.astate = spal_pkg::A_WAIT_WR;
              end
              spal_pkg::K_ST_PTR: begin
                if (l.op[spal_pkg::PTR_SEL_BIT]) begin
                  next_l.ptr[15:8] = in_byte;
                end else begin
                  next_l.ptr[7:0] = in_byte;
                end
              end
              spal_pkg::K_CS_ST: begin
                css_we = 1'b1;
                if (l.op[3:0] == spal_pkg::CSS_PHY_CTRL) begin
                  next_l.guard = in_byte;
                end
              end
              default: next_l.astate = spal_pkg::A_IDLE;
            endcase
          end
        end
        spal_pkg::A_KEY: begin
          if (in_vld) begin
            next_l.held_vld = 1'b0;
            next_l.key = {in_byte, l.key[63:8]};
            next_l.key_cnt = l.key_cnt + 3'h1;
            if (l.key_cnt == spal_pkg::KEY_LAST) begin
              next_l.key_tgl = !l.key_tgl;
              next_l.astate = spal_pkg::A_IDLE;
            end
          end
        end
        spal_pkg::A_WAIT_WR: begin
          // a byte arriving while the write completes is kept for the idle state
          if (rx_valid) begin
            next_l.held = rx_byte;
            next_l.held_vld = 1'b1;
          end
          if (ack_edge) begin
            next_l.astate = spal_pkg::A_IDLE;
          end
        end
        spal_pkg::A_WAIT_RD: begin
          if (ack_edge) begin
            next_l.tx_byte = s.rdata;
            next_l.tx_start = 1'b1;
            next_l.astate = spal_pkg::A_TX;
          end
        end
        spal_pkg::A_CS_RD: begin
          if (l.op[3:0] == spal_pkg::CSS_IDENT) begin
            next_l.tx_byte = IDENT_CODE;
          end else if (l.op[3:0] == spal_pkg::CSS_PHY_CTRL) begin
            next_l.tx_byte = l.guard;
          end else begin
            next_l.tx_byte = css_rdata;
          end
          next_l.tx_start = 1'b1;
          next_l.astate = spal_pkg::A_TX;
        end
        spal_pkg::A_TX: begin
          if (tx_done) begin
            next_l.astate = spal_pkg::A_IDLE;
          end
        end
        default: next_l.astate = spal_pkg::A_ERR;
      endcase
    end
  end

  always_ff @(posedge prog_clock_in) begin
    if (link_rst) begin
      l <= '0;
      l.guard <= spal_pkg::GUARD_RESET;
    end else begin
      l <= next_l;
    end
  end

  // system side: request and key toggles synchronised, words held stable by the link side
  always_comb begin
    next_s = s;
    next_s.req_s1 = l.req_tgl;
    next_s.req_s2 = s.req_s1;
    next_s.req_s3 = s.req_s2;
    next_s.key_s1 = l.key_tgl;
    next_s.key_s2 = s.key_s1;
    next_s.key_s3 = s.key_s2;
    next_s.key_valid = 1'b0;
    if (s.req_s2 ^ s.req_s3) begin
      next_s.bus_valid = 1'b1;
      next_s.bus_req = l.req;
    end else if (s.bus_valid && bus_ready) begin
      next_s.bus_valid = 1'b0;
      next_s.rdata = bus_rdata;
      next_s.ack_tgl = !s.ack_tgl;
    end
    if (s.key_s2 ^ s.key_s3) begin
      next_s.key_value = l.key;
      next_s.key_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign bus_valid = s.bus_valid;
  assign bus_req = s.bus_req;
  assign key_valid = s.key_valid;
  assign key_value = s.key_value;

  chk_exc_to_err: assert property (@(posedge prog_clock_in) disable iff (link_rst)
    (any_exc && !(l.astate == spal_pkg::A_ERR && exc.brk)) |=> l.astate == spal_pkg::A_ERR)
    else $error("exception did not enter error state");
  chk_err_hold: assert property (@(posedge prog_clock_in) disable iff (link_rst)
    (l.astate == spal_pkg::A_ERR && !exc.brk) |=> l.astate == spal_pkg::A_ERR)
    else $error("error state left without break");
  chk_guard_reset: assert property (@(posedge prog_clock_in) disable iff (link_rst)
    $fell(link_rst) |-> l.guard == spal_pkg::GUARD_RESET)
    else $error("guard setting not at reset value");
  chk_tx_direction: assert property (@(posedge prog_clock_in) disable iff (link_rst)
    tx_busy |-> l.astate == spal_pkg::A_TX)
    else $error("transmitting outside reply phase");
  chk_reply_sent: assert property (@(posedge prog_clock_in) disable iff (link_rst)
    (l.astate == spal_pkg::A_CS_RD && !any_exc) |=> l.tx_start ##1 tx_busy)
    else $error("read reply not started");
  chk_ptr_postinc: assert property (@(posedge prog_clock_in) disable iff (link_rst)
    (l.astate == spal_pkg::A_IDLE && in_vld && !any_exc && in_byte == spal_pkg::OP_LD_INC)
    |=> l.ptr == $past(l.ptr) + 16'h0001)
    else $error("pointer not incremented");
  chk_ptr_store: assert property (@(posedge prog_clock_in) disable iff (link_rst)
    (l.astate == spal_pkg::A_OPER && in_vld && !any_exc && l.kind == spal_pkg::K_ST_PTR && !l.op[0])
    |=> (l.ptr[7:0] == $past(in_byte) && l.ptr[15:8] == $past(l.ptr[15:8])))
    else $error("pointer low byte not stored");
  chk_key_count: assert property (@(posedge prog_clock_in) disable iff (link_rst)
    (l.astate == spal_pkg::A_KEY && in_vld && !any_exc && l.key_cnt == spal_pkg::KEY_LAST)
    |=> ($changed(l.key_tgl) && l.astate == spal_pkg::A_IDLE))
    else $error("key not completed after eight bytes");

endmodule : spal_top

/* File: spal_prog.sv */
// programmer model: drives the shared data wire and reads replies
// assumes the bench resolves the wire from both drivers and a pull-up
`timescale 1ns/1ps
module spal_prog (
  input wire logic link_clk,
  input wire logic line,
  input wire logic oe,
  output logic drv_en,
  output logic drv_val
);
  initial begin
    drv_en = 1'b0;
    drv_val = 1'b1;
  end
  task automatic put(input logic b);
    @(negedge link_clk);
    drv_en = 1'b1;
    drv_val = b;
  endtask : put
  task automatic rel();
    @(negedge link_clk);
    drv_en = 1'b0;
    drv_val = 1'b1;
  endtask : rel
  // bad parity only provokes the receive error path
  task automatic send(input logic [7:0] b, input logic bad);
    put(1'b1);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(b[i]);
    put(^b ^ bad);
    put(1'b1);
    put(1'b1);
    rel();
  endtask : send
  task automatic brk();
    put(1'b1);
    repeat (12) put(1'b0);
    put(1'b1);
    rel();
  endtask : brk
  task automatic recv(output logic [7:0] d, output logic ok, output int n);
    logic [10:0] s;
    d = 8'h00;
    ok = 1'b0;
    n = 0;
    @(posedge link_clk);
    while (line !== 1'b0 && n < 600) begin
      @(posedge link_clk);
      n++;
    end
    if (n < 600) begin
      for (int i = 0; i < 11; i++) begin
        @(posedge link_clk);
        s[i] = line;
      end
      d = s[7:0];
      ok = (s[8] === ^s[7:0]) && (s[10:9] === 2'b11);
    end
  endtask : recv
  // pull the wire low during a released guard bit
  task automatic collide();
    for (int i = 0; i < 600 && oe !== 1'b1; i++) @(posedge link_clk);
    for (int i = 0; i < 20 && oe !== 1'b0; i++) @(posedge link_clk);
    put(1'b0);
    rel();
  endtask : collide
endmodule : spal_prog

/* File: spal_top_tb.sv */
// self-checking bench for the serial programming access layer
// assumes spal_prog as the programmer and a free-running link clock
`timescale 1ns/1ps
module spal_top_tb;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic bus_ready = 1'b0;
  logic [7:0] bus_rdata = 8'h00;
  logic data_out, data_oe, bus_valid, key_valid, line, drv_en, drv_val, ok;
  logic [63:0] key_value;
  logic [63:0] key_seen = 64'h0;
  logic [7:0] d;
  spal_pkg::spal_bus_req_t bus_req, last_req;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int bus_cnt = 0;
  int n, c;
  initial forever #25 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  assign line = data_oe ? data_out : (drv_en ? drv_val : 1'b1);
  spal_top #(.IDENT_CODE(8'h3C)) DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .prog_clock_in(link_clk),
    .prog_data_in(line), .prog_data_out(data_out), .prog_data_oe(data_oe), .bus_valid(bus_valid),
    .bus_req(bus_req), .bus_ready(bus_ready), .bus_rdata(bus_rdata), .key_valid(key_valid), .key_value(key_value));
  spal_prog prog (.link_clk(link_clk), .line(line), .oe(data_oe), .drv_en(drv_en), .drv_val(drv_val));
  always @(negedge sys_clk) begin
    bus_ready <= bus_valid & ~bus_ready;
    bus_rdata <= bus_req.addr[7:0] ^ 8'hA5;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (bus_valid && bus_ready) begin
      last_req <= bus_req;
      bus_cnt++;
    end
    if (key_valid) key_seen <= key_value;
    if (cyc == 6000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wr2(input logic [7:0] op, input logic [7:0] v);
    prog.send(op, 1'b0);
    prog.send(v, 1'b0);
  endtask : wr2
  task automatic rd(input logic [7:0] op);
    prog.send(op, 1'b0);
    prog.recv(d, ok, n);
  endtask : rd
  task automatic wait_bus();
    for (int i = 0; i < 200 && bus_cnt == c; i++) @(posedge sys_clk);
    #1;
  endtask : wait_bus
  task automatic t_reset();
    chk("oe", 1'b0, data_oe);
    rd(8'h82);
    chk("guard rst", 8'h80, d);
    chk("idle bits", 1'b1, n >= 130);
    wr2(8'hC2, 8'h04);
    rd(8'h82);
    chk("guard", 8'h04, d);
    wr2(8'hC5, 8'h6B);
    rd(8'h85);
    chk("css mem", 8'h6B, d);
    chk("frame", 1'b1, ok);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_ptr();
    wr2(8'h68, 8'h34);
    wr2(8'h69, 8'h12);
    rd(8'h24);
    chk("ld data", 8'h34 ^ 8'hA5, d);
    chk("ld req", 18'h01234, {last_req.write, last_req.io, last_req.addr});
    c = bus_cnt;
    wr2(8'h64, 8'h77);
    wait_bus();
    chk("st req", {2'b10, 16'h1235, 8'h77}, last_req);
    rd(8'h20);
    chk("ld inc", 18'h01236, {last_req.write, last_req.io, last_req.addr});
    $display("t_ptr done");
  endtask : t_ptr
  task automatic t_io();
    c = bus_cnt;
    wr2(8'hF5, 8'h5C);
    wait_bus();
    chk("io wr", {2'b11, 16'h0035, 8'h5C}, last_req);
    rd(8'h7A);
    chk("io rd", 8'h3A ^ 8'hA5, d);
    chk("io addr", 18'h1003A, {last_req.write, last_req.io, last_req.addr});
    $display("t_io done");
  endtask : t_io
  task automatic t_key();
    prog.send(8'hE0, 1'b0);
    for (int i = 0; i < 8; i++) prog.send(8'h10 + 8'(i), 1'b0);
    repeat (10) @(posedge sys_clk);
    chk("key", 64'h1716151413121110, key_seen);
    $display("t_key done");
  endtask : t_key
  task automatic t_err();
    prog.send(8'h82, 1'b1);
    rd(8'h82);
    chk("err quiet", 1'b0, ok);
    prog.brk();
    rd(8'h82);
    chk("brk exit", 8'h04, d);
    prog.send(8'h8F, 1'b0);
    prog.collide();
    prog.recv(d, ok, n);
    chk("coll stop", 1'b0, ok);
    prog.brk();
    prog.send(8'h00, 1'b0);
    rd(8'h82);
    chk("bad op", 1'b0, ok);
    prog.brk();
    prog.send(8'hC3, 1'b0);
    prog.brk();
    prog.brk();
    rd(8'h8F);
    chk("ident", 8'h3C, d);
    $display("t_err done");
  endtask : t_err
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_ptr();
    t_io();
    t_key();
    t_err();
    results();
  end
endmodule : spal_top_tb
